// File: logic/pap_fifo.sv
// Purpose: eight-deep word store shared by all channels
// Assumes: caller never pushes while full; a pop while empty is ignored
// Notes: flip-flop storage addressed by read and write index
`timescale 1ns/1ps
`default_nettype none
module pap_fifo
   import pap_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   pap_word_if.store port
);
   logic [PAP_FIFO_DEPTH-1:0][PAP_WORD_W-1:0] mem_reg, mem_next;
   logic [PAP_PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [PAP_COUNT_W-1:0] cnt_reg, cnt_next;
   logic do_push, do_pop;

   always_comb begin
      do_push = port.push && !port.flush;
      do_pop = port.pop && !port.flush && (cnt_reg != '0);
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (port.flush) begin
         wr_next = '0;
         rd_next = '0;
         cnt_next = '0;
      end else begin
         if (do_push) begin
            mem_next[wr_reg] = port.push_data;
            wr_next = wr_reg + 3'h1;
         end
         if (do_pop) begin
            rd_next = rd_reg + 3'h1;
         end
         cnt_next = cnt_reg + {3'h0, do_push} - {3'h0, do_pop};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_reg <= '0;
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   assign port.head = mem_reg[rd_reg];
   assign port.count = cnt_reg;
   assign port.full = (cnt_reg == 4'(PAP_FIFO_DEPTH));
   assign port.empty = (cnt_reg == '0);
endmodule : pap_fifo
`default_nettype wire

// File: logic/pap_top.sv
// Purpose: parallel acquisition packer feeding the shared input fifo
// Assumes: serial channel words arrive on this clock; parallel pins do not
// Notes: pin inputs pass two flip-flops before the edge detector
`timescale 1ns/1ps
`default_nettype none
module pap_top
   import pap_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic port_global_enable,
   input wire logic global_dma_enable,
   input wire logic overflow_clear,
   input wire logic [PAP_CHANNELS-1:0] port_control_second,
   input wire logic [PAP_WORD_W-1:0] parallel_control,
   input wire logic routed_clock_in,
   input wire logic routed_hold_in,
   input wire logic [PAP_SAMPLE_W-1:0] routed_sample_in,
   input wire logic port_clock_in,
   input wire logic port_hold_in,
   input wire logic [PAP_SAMPLE_W-1:0] port_sample_in,
   input wire logic [PAP_CHANNELS-1:0] serial_word_valid,
   input wire logic [PAP_CHANNELS-1:0][PAP_WORD_W-1:0] serial_word_data,
   input wire logic core_read,
   input wire logic dma_read,
   output logic [PAP_WORD_W-1:0] fifo_read_buffer,
   output logic read_valid,
   output logic [PAP_WORD_W-1:0] interface_status,
   output logic overflow_clear_readback,
   output logic word_ready_strobe
);
   localparam int PIN_W = 2 * (PAP_SAMPLE_W + 2);

   // index of the last sample in a word for a mode (one less than samples per word)
   function automatic logic [1:0] last_index(input logic [1:0] mode);
      case (mode)
         PAP_PACK4: last_index = 2'h3;
         PAP_PACK3: last_index = 2'h2;
         PAP_PACK2: last_index = 2'h1;
         default: last_index = 2'h0;
      endcase
   endfunction : last_index

   // place one sample into the word being built
   function automatic logic [PAP_WORD_W-1:0] pack_insert(
      input logic [PAP_WORD_W-1:0] word,
      input logic [PAP_SAMPLE_W-1:0] s,
      input logic [1:0] mode,
      input logic [1:0] idx);
      logic [PAP_WORD_W-1:0] w;
      w = word;
      case (mode)
         PAP_PACK1: w = {s, 12'h000};
         PAP_PACK2: begin
            if (idx == 2'h0) w[15:0] = s[19:4];
            else w[31:16] = s[19:4];
         end
         PAP_PACK3: begin
            if (idx == 2'h0) w[9:0] = s[19:10];
            else if (idx == 2'h1) w[20:10] = s[19:9];
            else w[31:21] = s[19:9];
         end
         default: w[8*idx +: 8] = s[19:12];
      endcase
      pack_insert = w;
   endfunction : pack_insert

   // reset release synchroniser
   logic rst_meta_reg, rst_n;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // pin synchronisers; both sources synced, then selected
   logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg, pin_raw;
   logic clk_prev_reg, clk_prev_next;
   logic acq_clk, acq_hold;
   logic [PAP_SAMPLE_W-1:0] acq_data;
   logic src_sel, edge_sel, par_en;
   logic [1:0] mode;

   assign pin_raw = {routed_clock_in, routed_hold_in, routed_sample_in,
                     port_clock_in, port_hold_in, port_sample_in};
   assign src_sel = parallel_control[PAP_SOURCE_BIT];
   assign edge_sel = parallel_control[PAP_EDGE_BIT];
   assign par_en = parallel_control[PAP_PAR_EN_BIT];
   assign mode = parallel_control[PAP_MODE_LSB +: 2];

   always_comb begin
      if (src_sel) begin
         {acq_clk, acq_hold, acq_data} = pin_sync_reg[PIN_W/2-1:0];
      end else begin
         {acq_clk, acq_hold, acq_data} = pin_sync_reg[PIN_W-1:PIN_W/2];
      end
      clk_prev_next = acq_clk;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         clk_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         clk_prev_reg <= clk_prev_next;
      end
   end

   // packer state
   logic [1:0] idx_reg, idx_next, mode_reg, mode_next;
   logic [PAP_WORD_W-1:0] word_reg, word_next, pword_reg, pword_next;
   logic pvalid_reg, pvalid_next;
   logic [1:0] strobe_cnt_reg, strobe_cnt_next;
   logic strobe_reg, strobe_next;
   logic latch, run;
   logic [PAP_WORD_W-1:0] base;

   always_comb begin
      // source must change data and hold on the opposite edge
      if (edge_sel) latch = acq_clk && !clk_prev_reg;
      else latch = !acq_clk && clk_prev_reg;
      run = port_global_enable && par_en;
      idx_next = idx_reg;
      word_next = word_reg;
      pvalid_next = 1'b0;
      pword_next = pword_reg;
      mode_next = mode;
      base = (idx_reg == 2'h0) ? PAP_WORD_RESET : word_reg;
      if (!run || mode != mode_reg) begin
         idx_next = 2'h0;
         word_next = PAP_WORD_RESET;
      end else if (latch && !acq_hold) begin
         // only sample bits reach the word, all 20 in PACK1 and the upper bits otherwise; no channel code
         word_next = pack_insert(base, acq_data, mode, idx_reg);
         if (idx_reg == last_index(mode)) begin
            idx_next = 2'h0;
            pvalid_next = 1'b1;
            pword_next = word_next;
         end else begin
            idx_next = idx_reg + 2'h1;
         end
      end
      // two-cycle strobe per packed word
      strobe_cnt_next = strobe_cnt_reg;
      if (pvalid_next) strobe_cnt_next = PAP_STROBE_CYCLES;
      else if (strobe_cnt_reg != 2'h0) strobe_cnt_next = strobe_cnt_reg - 2'h1;
      strobe_next = (strobe_cnt_next != 2'h0);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idx_reg <= 2'h0;
         mode_reg <= 2'h0;
         word_reg <= PAP_WORD_RESET;
         pword_reg <= PAP_WORD_RESET;
         pvalid_reg <= 1'b0;
         strobe_cnt_reg <= 2'h0;
         strobe_reg <= 1'b0;
      end else begin
         idx_reg <= idx_next;
         mode_reg <= mode_next;
         word_reg <= word_next;
         pword_reg <= pword_next;
         pvalid_reg <= pvalid_next;
         strobe_cnt_reg <= strobe_cnt_next;
         strobe_reg <= strobe_next;
      end
   end

   // channel arrival into one-word holding slots
   pap_word_if fq();
   logic [PAP_CHANNELS-1:0] arrive, grant, drop;
   logic [PAP_CHANNELS-1:0][PAP_WORD_W-1:0] in_data;
   logic [PAP_CHANNELS-1:0] hold_v_reg, hold_v_next;
   logic [PAP_CHANNELS-1:0][PAP_WORD_W-1:0] hold_d_reg, hold_d_next;
   logic [PAP_CHANNELS-1:0] ovf_reg, ovf_next;
   logic accept;

   // global and channel enables gate capture
   assign accept = port_global_enable && global_dma_enable;

   generate
      for (genvar c = 0; c < PAP_CHANNELS; c++) begin : g_chan
         if (c == 0) begin : g_shared
            // one kind of driver per bit vector keeps strict elaborators quiet
            assign arrive[c] = (par_en ? pvalid_reg : serial_word_valid[c]) && accept
                               && port_control_second[c];
            assign in_data[c] = par_en ? pword_reg : serial_word_data[c];
         end else begin : g_serial
            assign arrive[c] = serial_word_valid[c] && accept && port_control_second[c];
            assign in_data[c] = serial_word_data[c];
         end
      end
   endgenerate

   // lowest channel first, one word into the fifo per cycle
   always_comb begin
      grant = '0;
      for (int c = 0; c < PAP_CHANNELS; c++) begin
         if (hold_v_reg[c] && grant == '0) grant[c] = 1'b1;
      end
      fq.push = (grant != '0) && !fq.full;
      fq.push_data = '0;
      for (int c = 0; c < PAP_CHANNELS; c++) begin
         if (grant[c]) fq.push_data = hold_d_reg[c];
      end
      drop = fq.full ? grant : '0;
      hold_v_next = hold_v_reg & ~grant;
      hold_d_next = hold_d_reg;
      for (int c = 0; c < PAP_CHANNELS; c++) begin
         if (arrive[c]) begin
            if (hold_v_next[c]) begin
               drop[c] = 1'b1;
            end else begin
               hold_v_next[c] = 1'b1;
               hold_d_next[c] = in_data[c];
            end
         end
      end
      if (!port_global_enable) hold_v_next = '0;
      // a new overflow beats a clear in the same cycle
      ovf_next = (ovf_reg & ~{PAP_CHANNELS{overflow_clear}}) | drop;
   end

   // fifo drain and status
   logic [PAP_WORD_W-1:0] rbuf_reg, rbuf_next, stat_reg, stat_next;
   logic rvalid_reg, rvalid_next;

   always_comb begin
      fq.flush = !port_global_enable;
      // core read drains, dma read drains only while global_dma_enable is set
      fq.pop = (core_read || (dma_read && global_dma_enable)) && !fq.empty;
      rvalid_next = fq.pop;
      rbuf_next = fq.pop ? fq.head : rbuf_reg;
      stat_next = PAP_STATUS_RESET;
      stat_next[PAP_FILL_LSB +: PAP_COUNT_W] = fq.count;
      stat_next[PAP_OVF_LSB +: PAP_CHANNELS] = ovf_reg;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_v_reg <= '0;
         hold_d_reg <= '0;
         ovf_reg <= '0;
         rbuf_reg <= PAP_WORD_RESET;
         rvalid_reg <= 1'b0;
         stat_reg <= PAP_STATUS_RESET;
      end else begin
         hold_v_reg <= hold_v_next;
         hold_d_reg <= hold_d_next;
         ovf_reg <= ovf_next;
         rbuf_reg <= rbuf_next;
         rvalid_reg <= rvalid_next;
         stat_reg <= stat_next;
      end
   end

   pap_fifo u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .port(fq.store)
   );

   // write-only bit has no storage; read side is a constant flop
   logic clr_rb_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) clr_rb_reg <= 1'b0;
      else clr_rb_reg <= 1'b0;
   end

   assign fifo_read_buffer = rbuf_reg;
   assign read_valid = rvalid_reg;
   assign interface_status = stat_reg;
   assign overflow_clear_readback = clr_rb_reg;
   assign word_ready_strobe = strobe_reg;
endmodule : pap_top
`default_nettype wire

// File: pkg/pap_pkg.sv
// Purpose: shared constants for the parallel acquisition packer
// Assumes: one 200 MHz clock domain
// Notes: bit positions refer to the control and status words
`default_nettype none
package pap_pkg;
   localparam int PAP_SAMPLE_W = 20;
   localparam int PAP_WORD_W = 32;
   localparam int PAP_CHANNELS = 8;
   localparam int PAP_FIFO_DEPTH = 8;
   localparam int PAP_PTR_W = 3;
   localparam int PAP_COUNT_W = 4;
   // parallel control word fields
   localparam int PAP_EDGE_BIT = 29;
   localparam int PAP_SOURCE_BIT = 26;
   localparam int PAP_PAR_EN_BIT = 0;
   localparam int PAP_MODE_LSB = 1;
   // status word fields
   localparam int PAP_FILL_LSB = 28;
   localparam int PAP_OVF_LSB = 0;
   // strobe width in clock cycles
   localparam logic [1:0] PAP_STROBE_CYCLES = 2'h2;
   localparam logic [31:0] PAP_STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] PAP_WORD_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {
      PAP_PACK4 = 2'h0,
      PAP_PACK3 = 2'h1,
      PAP_PACK2 = 2'h2,
      PAP_PACK1 = 2'h3
   } pap_mode_t;
endpackage : pap_pkg
`default_nettype wire

// File: pkg/pap_word_if.sv
// Purpose: carrier between the packer top and its fifo
// Assumes: push is never raised while full
// Notes: flush empties the store in one cycle
`timescale 1ns/1ps
`default_nettype none
interface pap_word_if;
   import pap_pkg::*;
   logic push;
   logic [PAP_WORD_W-1:0] push_data;
   logic pop;
   logic flush;
   logic [PAP_WORD_W-1:0] head;
   logic [PAP_COUNT_W-1:0] count;
   logic full;
   logic empty;
   modport fill (output push, push_data, pop, flush, input head, count, full, empty);
   modport store (input push, push_data, pop, flush, output head, count, full, empty);
endinterface : pap_word_if
`default_nettype wire

// File: sim/pap_src_model.sv
// Purpose: parallel sample source for pap_top
// Assumes: pin half period of four clocks
// Notes: pin clock stands still between samples
`timescale 1ns/1ps
`default_nettype none
module pap_src_model
   import pap_pkg::*;
(
   input wire logic clock,
   input wire logic rise,
   output logic pclk,
   output logic hold,
   output logic [PAP_SAMPLE_W-1:0] data
);
   initial begin
      pclk = 1'b0;
      hold = 1'b0;
      data = 20'h0_0000;
   end
   // data and hold move with the inactive edge only
   task automatic send(input logic [PAP_SAMPLE_W-1:0] s, input logic h);
      @(posedge clock);
      pclk <= ~rise;
      data <= s;
      hold <= h;
      repeat (4) @(posedge clock);
      pclk <= rise;
      repeat (4) @(posedge clock);
      pclk <= ~rise;
      // released pins must not keep a stale sample
      data <= ~s;
      hold <= ~h;
   endtask : send
endmodule : pap_src_model
`default_nettype wire

// File: sim/pap_top_monitor.sv
// Purpose: port checker for pap_top
// Assumes: one clock, nrst low resets
// Notes: status lags the fifo state by one cycle
`timescale 1ns/1ps
`default_nettype none
module pap_top_monitor
   import pap_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic port_global_enable,
   input wire logic global_dma_enable,
   input wire logic overflow_clear,
   input wire logic [PAP_CHANNELS-1:0] serial_word_valid,
   input wire logic core_read,
   input wire logic dma_read,
   input wire logic read_valid,
   input wire logic [PAP_WORD_W-1:0] interface_status,
   input wire logic overflow_clear_readback,
   input wire logic word_ready_strobe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   a_clear_reads_zero:
      assert property (!overflow_clear_readback) else $error("clear readback high");
   a_strobe_two:
      assert property ($rose(word_ready_strobe) |=> word_ready_strobe ##1 !word_ready_strobe)
      else $error("strobe not two cycles");
   a_pop_cause:
      assert property (read_valid |-> $past(core_read) || ($past(dma_read) &&
         $past(global_dma_enable))) else $error("read data without a read");
   a_dma_gated:
      assert property (dma_read && !global_dma_enable && !core_read |=> !read_valid)
      else $error("dma read taken while disabled");
   a_spare_zero:
      assert property (interface_status[27:8] == 20'h0_0000) else $error("status spare set");
   a_fill_bound:
      assert property (interface_status[31:28] <= 4'h8) else $error("fill count above 8");
   a_flush_empty:
      assert property (!port_global_enable [*3] |-> interface_status[31:28] == 4'h0)
      else $error("fifo not flushed");
   // waiting slots may still drop for up to eight cycles, and status lags by one
   a_clear_flags:
      assert property ((overflow_clear && serial_word_valid == 8'h00 && !word_ready_strobe)
         [*8] ##1 overflow_clear |-> ##2 interface_status[7:0] == 8'h00)
      else $error("overflow not cleared");
   c_strobe: cover property ($rose(word_ready_strobe));
   c_pop: cover property (read_valid);
   c_ovf: cover property (interface_status[7:0] != 8'h00);
endmodule : pap_top_monitor
bind pap_top pap_top_monitor u_pap_top_monitor (.clock(clock), .nrst(nrst),
   .port_global_enable(port_global_enable), .global_dma_enable(global_dma_enable),
   .overflow_clear(overflow_clear), .serial_word_valid(serial_word_valid),
   .core_read(core_read), .dma_read(dma_read), .read_valid(read_valid),
   .interface_status(interface_status), .overflow_clear_readback(overflow_clear_readback),
   .word_ready_strobe(word_ready_strobe));
`default_nettype wire

// File: sim/tb_pap_top.sv
// Purpose: self-checking bench for pap_top
// Assumes: 200 MHz clock, two source models
// Notes: checks wait out the status lag
`timescale 1ns/1ps
`default_nettype none
module tb_pap_top
   import pap_pkg::*;
;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic port_global_enable = 1'b0;
   logic global_dma_enable = 1'b0;
   logic overflow_clear = 1'b0;
   logic core_read = 1'b0;
   logic dma_read = 1'b0;
   logic [PAP_CHANNELS-1:0] port_control_second = 8'h00;
   logic [PAP_WORD_W-1:0] parallel_control = 32'h0;
   logic [PAP_CHANNELS-1:0] serial_word_valid = 8'h00;
   logic [PAP_CHANNELS-1:0][PAP_WORD_W-1:0] serial_word_data = '0;
   logic rclk, rhold, pclk, phold, rd_valid, clr_rb, strobe;
   logic [PAP_SAMPLE_W-1:0] rdat, pdat;
   logic [PAP_WORD_W-1:0] rd_word, status, w;
   logic [PAP_WORD_W-1:0] q[$];
   logic [PAP_SAMPLE_W-1:0] smp[4] = '{20'hA_BCDE, 20'h1_2345, 20'hF_0F0F, 20'h5_A5A5};
   int n_errors = 0;
   int checked = 0;
   int strobes = 0;
   always #2.5 clock = ~clock;
   always @(posedge clock) if (strobe === 1'b1) strobes <= strobes + 1;
   pap_top u_pap_top (.clock(clock), .nrst(nrst), .port_global_enable(port_global_enable),
      .global_dma_enable(global_dma_enable), .overflow_clear(overflow_clear),
      .port_control_second(port_control_second), .parallel_control(parallel_control),
      .routed_clock_in(rclk), .routed_hold_in(rhold), .routed_sample_in(rdat),
      .port_clock_in(pclk), .port_hold_in(phold), .port_sample_in(pdat),
      .serial_word_valid(serial_word_valid), .serial_word_data(serial_word_data),
      .core_read(core_read), .dma_read(dma_read), .fifo_read_buffer(rd_word),
      .read_valid(rd_valid), .interface_status(status),
      .overflow_clear_readback(clr_rb), .word_ready_strobe(strobe));
   pap_src_model u_src_r (.clock(clock), .rise(parallel_control[PAP_EDGE_BIT]),
      .pclk(rclk), .hold(rhold), .data(rdat));
   pap_src_model u_src_p (.clock(clock), .rise(parallel_control[PAP_EDGE_BIT]),
      .pclk(pclk), .hold(phold), .data(pdat));
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   // settle first: a late synced pin edge must not meet the new edge select
   task automatic ctl(input logic [1:0] m, input logic src, input logic rise);
      tick(4);
      parallel_control <= {2'h0, rise, 2'h0, src, 23'h0, m, 1'b1};
      tick(2);
   endtask : ctl
   task automatic ser(input int c, input logic [31:0] d);
      @(posedge clock);
      serial_word_valid[c] <= 1'b1;
      serial_word_data[c] <= d;
      @(posedge clock);
      serial_word_valid <= 8'h00;
      tick(3);
   endtask : ser
   task automatic pop(input logic dma, input logic ev, input logic [31:0] e);
      @(posedge clock);
      core_read <= ~dma;
      dma_read <= dma;
      @(posedge clock);
      core_read <= 1'b0;
      dma_read <= 1'b0;
      @(posedge clock);
      chk("read_valid", {31'h0, rd_valid}, {31'h0, ev});
      if (ev) chk("read data", rd_word, e);
   endtask : pop
   task automatic cnt(input logic [3:0] e);
      tick(8);
      chk("fill count", {28'h0, status[31:28]}, {28'h0, e});
   endtask : cnt
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   initial begin
      #50us;
      n_errors++;
      end_sim();
   end
   initial begin
      tick(5);
      nrst <= 1'b1;
      tick(4);
      port_global_enable <= 1'b1;
      global_dma_enable <= 1'b1;
      port_control_second <= 8'hFF;
      for (int m = 3; m >= 0; m--) begin
         ctl(2'(m), 1'b0, 1'b1);
         w = '0;
         for (int k = 0; k < 4 - m; k++) begin
            // a masked sample just before the last one
            if (k == 3 - m) u_src_r.send(20'hF_FFFF, 1'b1);
            u_src_r.send(smp[k], 1'b0);
            case (m)
               3: w = {smp[k], 12'h000};
               2: w[16*k +: 16] = smp[k][19:4];
               1: w[(k == 0 ? 0 : 11*k-1) +: 11] = k == 0 ? {1'b0, smp[k][19:10]} : smp[k][19:9];
               default: w[8*k +: 8] = smp[k][19:12];
            endcase
         end
         q.push_back(w);
      end
      cnt(4'h4);
      chk("strobe cycles", 32'(strobes), 32'h8);
      ser(0, 32'h5555_5555);
      cnt(4'h4);
      pop(1'b1, 1'b1, q.pop_front());
      repeat (3) pop(1'b0, 1'b1, q.pop_front());
      pop(1'b0, 1'b0, 32'h0);
      $display("test packing done");
      for (int i = 0; i < 9; i++) ser(1, 32'h1000_0000 + i);
      cnt(4'h8);
      chk("overflow", {24'h0, status[7:0]}, 32'h2);
      overflow_clear <= 1'b1;
      tick(10);
      chk("clear readback", {31'h0, clr_rb}, 32'h0);
      overflow_clear <= 1'b0;
      cnt(4'h8);
      chk("overflow", {24'h0, status[7:0]}, 32'h0);
      global_dma_enable <= 1'b0;
      pop(1'b1, 1'b0, 32'h0);
      global_dma_enable <= 1'b1;
      pop(1'b0, 1'b1, 32'h1000_0000);
      port_global_enable <= 1'b0;
      cnt(4'h0);
      port_global_enable <= 1'b1;
      $display("test overflow done");
      ctl(2'h3, 1'b1, 1'b1);
      u_src_r.send(20'h3_3333, 1'b0);
      cnt(4'h0);
      u_src_p.send(20'h7_8901, 1'b0);
      ctl(2'h3, 1'b1, 1'b0);
      u_src_p.send(20'h2_4680, 1'b0);
      ctl(2'h0, 1'b1, 1'b0);
      u_src_p.send(20'hC_0000, 1'b0);
      u_src_p.send(20'hD_0000, 1'b0);
      ctl(2'h3, 1'b1, 1'b0);
      u_src_p.send(20'hE_1357, 1'b0);
      cnt(4'h3);
      pop(1'b0, 1'b1, 32'h7890_1000);
      pop(1'b0, 1'b1, 32'h2468_0000);
      pop(1'b0, 1'b1, 32'hE135_7000);
      $display("test source done");
      end_sim();
   end
endmodule : tb_pap_top
`default_nettype wire
